// ### current_dac_fault_monitor.sv
`timescale 1ns/1ps
module current_dac_fault_monitor
  import cdfm_pkg::*;
#(
  parameter int RES_BITS = 16,
  parameter int WD_TICKS_P0 = WD_TICKS_0,
  parameter int WD_TICKS_P1 = WD_TICKS_1,
  parameter int WD_TICKS_P2 = WD_TICKS_2,
  parameter int WD_TICKS_P3 = WD_TICKS_3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic latchIn,
  input wire logic outputClearPin,
  input wire logic logicSupplyOk,
  input wire logic analogSupplyOk,
  input wire logic openLoadIn,
  input wire logic headroomLowIn,
  input wire logic dieHotIn,
  input wire logic dieCooledIn,
  input wire logic alarmLineIn,
  output logic currentOutputPinOn,
  output logic [14:0] currentOutputPinUa,
  output logic [RES_BITS-1:0] dacCode,
  output logic [2:0] rangeSel,
  output logic alarmOut,
  output logic alarmOe,
  output logic serialOut,
  output logic serialOutOe,
  output logic watchdogFaultFlag,
  output logic frameCheckFaultFlag
);
  logic logicOkS, analogOkS, clearS, latchS, openS, headS, hotS, coolS;
  logic lineLowS, coreRst, regRst;
  logic [LATCH_DELAY:0] latchPipe_r;
  logic latchRise, latchEpoch_r;
  logic [31:0] frameWord;
  logic frameIs32, frameTglL, frameTglS, frameSeen_r, frameNew;
  logic crcOk, frameBad, pending_r, applyFrame, noopLatch;
  logic [23:0] pendWord_r;
  logic [15:0] wrVal;
  logic wrData, wrControl, wrConfig, wrReadSel, wdRefresh, softRst;
  logic [15:0] control_r, config_r, readVal, statusWord;
  logic outputDriveOnBit, watchdogOnBit, frameCheckOnBit;
  logic [1:0] watchdogPeriodSel;
  logic [2:0] rangeBits;
  logic [RES_BITS-1:0] dataReg_r, dacCode_r;
  logic outOn_r, thermal_r, alarmOe_r, alarmOut_r;
  logic [14:0] outUa_r;
  logic [2:0] rangeOut_r;
  logic [3:0] oscAcc_r;
  logic [4:0] oscSum;
  logic oscTick, wdExpire, wdFault_r, crcFault_r;
  logic [23:0] wdCnt_r;
  logic [31:0] readWord_r;
  logic readTgl_r;

  // Remainder of a 32-bit message, most significant bit first.
  // shared generator.
  function automatic logic [7:0] crcRem(input logic [31:0] msg);
    logic [7:0] r;
    logic fb;
    r = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      fb = r[7];
      r = {r[6:0], msg[i]};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // Scales a code onto the span of the selected range, in microamps.
  function automatic logic [14:0] scaleUa(input logic [2:0] rng,
                                          input logic [RES_BITS-1:0] code);
    logic [31:0] span, off, prod;
    span = SPAN_20_UA;
    off = 32'h0000_0000;
    if (rng == RANGE_0_24) begin
      span = SPAN_24_UA;
    end else if (rng == RANGE_4_20) begin
      span = SPAN_16_UA;
      off = OFFSET_4_UA;
    end
    prod = span * 32'(code);
    return 15'((prod >> RES_BITS) + off);
  endfunction

  // Watchdog limit in oscillator ticks for each period select.
  function automatic logic [23:0] wdLimit(input logic [1:0] sel);
    logic [23:0] lim;
    case (sel)
      2'h0: lim = 24'(WD_TICKS_P0);
      2'h1: lim = 24'(WD_TICKS_P1);
      2'h2: lim = 24'(WD_TICKS_P2);
      default: lim = 24'(WD_TICKS_P3);
    endcase
    return lim;
  endfunction

  // Every pin input except rst_n and the serial clock and data passes two flops before use.
  bit_sync #(.WIDTH(9)) uPinSync (
    .clk(ref_clk),
    .rstN(rst_n),
    .d({logicSupplyOk, analogSupplyOk, outputClearPin, latchIn, openLoadIn,
        headroomLowIn, dieHotIn, dieCooledIn, alarmLineIn}),
    .q({logicOkS, analogOkS, clearS, latchS, openS, headS, hotS, coolS,
        lineLowS})
  );

  assign coreRst = !rst_n || !(logicOkS && analogOkS);
  assign regRst = coreRst || softRst;

  // Latch edge, held back so a frame finishing just before it lands first.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      latchPipe_r <= '0;
      latchEpoch_r <= 1'b0;
    end else begin
      latchPipe_r <= {latchPipe_r[LATCH_DELAY-1:0], latchS};
      if (latchRise) begin
        latchEpoch_r <= ~latchEpoch_r;
      end
    end
  end
  assign latchRise = latchPipe_r[LATCH_DELAY-1] & ~latchPipe_r[LATCH_DELAY];

  frame_link uLink (
    .serialClk(serialClk),
    .rstN(rst_n),
    .serialIn(serialIn),
    .latchEpoch(latchEpoch_r),
    .frameCheckOn(frameCheckOnBit),
    .readTgl(readTgl_r),
    .readWord(readWord_r),
    .frameWord(frameWord),
    .frameIs32(frameIs32),
    .frameTgl(frameTglL),
    .serialOut(serialOut),
    .serialOutOe(serialOutOe)
  );

  // Frame toggle from the link; its word stays put until the next frame.
  bit_sync #(.WIDTH(1)) uFrameSync (
    .clk(ref_clk),
    .rstN(rst_n),
    .d(frameTglL),
    .q(frameTglS)
  );

  assign frameNew = frameTglS ^ frameSeen_r;
  assign crcOk = (crcRem(frameWord) == 8'h00);
  assign frameBad = frameNew && frameIs32 && frameCheckOnBit && !crcOk;

  // Holds the last frame, pending only if it passed its check, until the latch edge commits it.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      frameSeen_r <= frameTglS;  // No stale frame is replayed after reset.
      pending_r <= 1'b0;
      pendWord_r <= '0;
    end else begin
      frameSeen_r <= frameTglS;
      if (frameNew) begin
        pending_r <= !frameBad;
        pendWord_r <= frameIs32 ? frameWord[31:8] : frameWord[23:0];
      end else if (latchRise) begin
        pending_r <= 1'b0;
      end
    end
  end

  assign applyFrame = latchRise && pending_r;
  assign noopLatch = latchRise && !pending_r;
  assign wrVal = pendWord_r[15:0];

  // Command decode of the committed frame.
  always_comb begin
    wrData = 1'b0;
    wrControl = 1'b0;
    wrConfig = 1'b0;
    wrReadSel = 1'b0;
    wdRefresh = 1'b0;
    softRst = 1'b0;
    if (!applyFrame) begin
      wrData = 1'b0;
    end else if (pendWord_r[23:16] == ADDR_DATA) begin
      wrData = 1'b1;
    end else if (pendWord_r[23:16] == ADDR_CONTROL) begin
      wrControl = 1'b1;
    end else if (pendWord_r[23:16] == ADDR_CONFIG) begin
      wrConfig = 1'b1;
    end else if (pendWord_r[23:16] == ADDR_READ_SEL) begin
      wrReadSel = 1'b1;
    end else if (pendWord_r[23:16] == ADDR_WD_REFRESH) begin
      wdRefresh = 1'b1;
    end else if (pendWord_r[23:16] == ADDR_SOFT_RESET) begin
      softRst = 1'b1;
    end
  end

  // Control and configuration words, cleared by either reset.
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      control_r <= CONTROL_RESET;
      config_r <= CONFIG_RESET;
    end else begin
      if (wrControl) begin
        control_r <= wrVal;
      end
      if (wrConfig) begin
        config_r <= wrVal;
      end
    end
  end
  assign outputDriveOnBit = control_r[CTRL_OUTPUT_DRIVE_ON_BIT_BIT];
  assign rangeBits = control_r[CTRL_RANGE_LSB +: 3];
  assign watchdogOnBit = config_r[CFG_WATCHDOG_ON_BIT_BIT];
  assign watchdogPeriodSel = config_r[CFG_WATCHDOG_PERIOD_SEL_LSB +: 2];
  assign frameCheckOnBit = config_r[CFG_FRAME_CHECK_ON_BIT_BIT];

  // Data word and applied code; clear wins over writes and restores.
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      dataReg_r <= '0;
      dacCode_r <= '0;
    end else if (clearS) begin
      dacCode_r <= '0;
    end else if (wrData) begin
      dataReg_r <= wrVal[15 -: RES_BITS];
      dacCode_r <= wrVal[15 -: RES_BITS];
    end else if (noopLatch) begin
      dacCode_r <= dataReg_r;
    end
  end

  // Output stage: disabled output reads as off and zero current.
  // off until enabled.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      outOn_r <= 1'b0;
      outUa_r <= '0;
      rangeOut_r <= '0;
    end else begin
      outOn_r <= outputDriveOnBit;
      outUa_r <= outputDriveOnBit ? scaleUa(rangeBits, dacCode_r) : '0;
      rangeOut_r <= rangeBits;
    end
  end

  // Thermal alarm with hysteresis between the hot and cooled sensors.
  // hold until cooled.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      thermal_r <= 1'b0;
    end else if (hotS) begin
      thermal_r <= 1'b1;
    end else if (coolS) begin
      thermal_r <= 1'b0;
    end
  end

  // Oscillator tick at the 8 MHz rate from the reference clock.
  assign oscSum = {1'b0, oscAcc_r} + {1'b0, OSC_STEP};
  assign oscTick = (oscSum >= {1'b0, OSC_MOD});
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      oscAcc_r <= '0;
    end else begin
      oscAcc_r <= oscTick ? 4'(oscSum - {1'b0, OSC_MOD}) : oscSum[3:0];
    end
  end

  assign wdExpire = watchdogOnBit && oscTick &&
                    (wdCnt_r >= wdLimit(watchdogPeriodSel) - 24'h000001);

  // Watchdog counter, restarted by each refresh frame.
  // idle when disabled.
  always_ff @(posedge ref_clk) begin
    if (regRst || !watchdogOnBit || wdRefresh || wdExpire) begin
      wdCnt_r <= '0;
    end else if (oscTick) begin
      wdCnt_r <= wdCnt_r + 24'h000001;
    end
  end

  // Sticky fault flags; a setting event wins over a clearing one.
  // watchdog flag clears.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      wdFault_r <= 1'b0;
      crcFault_r <= 1'b0;
    end else begin
      if (wdExpire) begin
        wdFault_r <= 1'b1;
      end else if (softRst || !watchdogOnBit) begin
        wdFault_r <= 1'b0;
      end
      if (frameBad) begin
        crcFault_r <= 1'b1;
      end else if (softRst || !frameCheckOnBit) begin
        crcFault_r <= 1'b0;
      end
    end
  end

  // Open-drain alarm: the pin is only ever pulled low.
  // any fault pulls low.
  always_ff @(posedge ref_clk) begin
    if (coreRst) begin
      alarmOe_r <= 1'b0;
      alarmOut_r <= 1'b0;
    end else begin
      alarmOut_r <= 1'b0;
      alarmOe_r <= openS || headS || thermal_r ||
                   (watchdogOnBit && wdFault_r) ||
                   (frameCheckOnBit && crcFault_r);
    end
  end

  // Readback selection of one internal word.
  assign statusWord = {10'h000, lineLowS, thermal_r, headS, openS,
                       crcFault_r, wdFault_r};
  always_comb begin
    case (wrVal[1:0])
      2'h0: readVal = statusWord;
      2'h1: readVal = 16'(dataReg_r) << (16 - RES_BITS);
      2'h2: readVal = control_r;
      default: readVal = config_r;
    endcase
  end

  // Readback word goes to the link with a toggle; CRC byte in checked mode.
  // CRC byte appended.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin  // Matches the link, which only the pin reset clears.
      readWord_r <= '0;
      readTgl_r <= 1'b0;
    end else if (wrReadSel) begin
      readWord_r <= {8'h00, readVal,
                     frameCheckOnBit ? crcRem({8'h00, readVal, 8'h00}) : 8'h00};
      readTgl_r <= ~readTgl_r;
    end
  end

  assign currentOutputPinOn = outOn_r;
  assign currentOutputPinUa = outUa_r;
  assign dacCode = dacCode_r;
  assign rangeSel = rangeOut_r;
  assign alarmOut = alarmOut_r;
  assign alarmOe = alarmOe_r;
  assign watchdogFaultFlag = wdFault_r;
  assign frameCheckFaultFlag = crcFault_r;

  chk_clear_forces_zero: assert property (
    @(posedge ref_clk) disable iff (regRst)
    clearS && !softRst |=> dacCode_r == '0)
    else $error("Code not zero while clear is high.");

  chk_clear_blocks_write: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    clearS && wrData |=> dataReg_r == $past(dataReg_r))
    else $error("Data accepted while clear is high.");

  chk_idle_frame_cmd_restores: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    noopLatch && !clearS |=> dacCode_r == $past(dataReg_r))
    else $error("Clockless latch did not restore the code.");

  chk_output_needs_enable: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    !outputDriveOnBit ##1 !outputDriveOnBit |-> !outOn_r && outUa_r == '0)
    else $error("Output driven while disabled.");

  chk_thermal_hold: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    thermal_r && !coolS |=> thermal_r)
    else $error("Thermal alarm dropped before cooling.");

  chk_alarm_pulls: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    (openS || headS || thermal_r) |=> alarmOe_r && !alarmOut)
    else $error("Alarm not pulled low on a fault.");

  chk_watchdog_idle: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    !watchdogOnBit |=> wdCnt_r == '0 && !wdExpire)
    else $error("Watchdog counting while disabled.");

  chk_watchdog_sticky: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    wdFault_r && watchdogOnBit && !softRst |=> wdFault_r)
    else $error("Watchdog fault cleared without cause.");

  chk_bad_frame_drop: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    frameBad |=> !pending_r && crcFault_r)
    else $error("Failed frame kept or fault not set.");

  chk_crc_off_clear: assert property (
    @(posedge ref_clk) disable iff (coreRst)
    !frameCheckOnBit ##1 !frameCheckOnBit |-> !crcFault_r)
    else $error("Frame fault set while checking disabled.");
endmodule

// ### cdfm_pkg.sv
package cdfm_pkg;
  // Serial command addresses carried in the top byte of each payload.
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_READ_SEL = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h55;
  localparam logic [7:0] ADDR_CONFIG = 8'h57;
  localparam logic [7:0] ADDR_WD_REFRESH = 8'h95;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h96;

  // Frame check generator x^8 + x^2 + x + 1, the x^8 term implied.
  localparam logic [7:0] CRC_POLY = 8'h07;

  // Frame lengths in serial clocks and the count held after realignment.
  localparam logic [5:0] FRAME_SHORT = 6'h18;
  localparam logic [5:0] FRAME_LONG = 6'h20;
  localparam logic [5:0] REALIGN_COUNT = 6'h03;

  // Field positions in the control and configuration words.
  localparam int CTRL_OUTPUT_DRIVE_ON_BIT_BIT = 12;
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CFG_WATCHDOG_PERIOD_SEL_LSB = 0;
  localparam int CFG_WATCHDOG_ON_BIT_BIT = 2;
  localparam int CFG_FRAME_CHECK_ON_BIT_BIT = 3;

  // Values after reset.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;

  // Output range codes and their spans in microamps.
  localparam logic [2:0] RANGE_4_20 = 3'h5;
  localparam logic [2:0] RANGE_0_20 = 3'h6;
  localparam logic [2:0] RANGE_0_24 = 3'h7;
  localparam logic [31:0] SPAN_20_UA = 32'h0000_4E20;
  localparam logic [31:0] SPAN_24_UA = 32'h0000_5DC0;
  localparam logic [31:0] SPAN_16_UA = 32'h0000_3E80;
  localparam logic [31:0] OFFSET_4_UA = 32'h0000_0FA0;

  // Clock rates and the oscillator tick derived from the reference clock.
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 8_000_000;
  localparam logic [3:0] OSC_STEP = 4'(OSC_HZ / 1_000_000);
  localparam logic [3:0] OSC_MOD = 4'(REF_CLK_HZ / 1_000_000);

  // Watchdog periods in milliseconds and in oscillator ticks.
  localparam int WD_MS_0 = 10;
  localparam int WD_MS_1 = 51;
  localparam int WD_MS_2 = 102;
  localparam int WD_MS_3 = 204;
  localparam int WD_TICKS_0 = OSC_HZ / 1000 * WD_MS_0;
  localparam int WD_TICKS_1 = OSC_HZ / 1000 * WD_MS_1;
  localparam int WD_TICKS_2 = OSC_HZ / 1000 * WD_MS_2;
  localparam int WD_TICKS_3 = OSC_HZ / 1000 * WD_MS_3;

  // Extra reference cycles that the latch edge waits for a frame to land.
  localparam int LATCH_DELAY = 2;
endpackage

// ### bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  // Two flops; only the second stage leaves the module.
  always_ff @(posedge clk) begin
    if (!rstN) begin
      meta_r <= '0;
      stable_r <= '0;
    end else begin
      meta_r <= d;
      stable_r <= meta_r;
    end
  end

  assign q = stable_r;
endmodule

// ### frame_link.sv
`timescale 1ns/1ps
module frame_link
  import cdfm_pkg::*;
(
  input wire logic serialClk,
  input wire logic rstN,
  input wire logic serialIn,
  input wire logic latchEpoch,
  input wire logic frameCheckOn,
  input wire logic readTgl,
  input wire logic [31:0] readWord,
  output logic [31:0] frameWord,
  output logic frameIs32,
  output logic frameTgl,
  output logic serialOut,
  output logic serialOutOe
);
  logic rstS, epochS, checkS, readTglS;
  logic epochSeen_r, readSeen_r, realign, done;
  logic [5:0] cnt_r, cntNxt, frameLen;
  logic [31:0] shift_r, shiftNxt, outShift_r;
  logic [31:0] frameWord_r;
  logic frameIs32_r, frameTgl_r, outOe_r;

  // Control levels and toggles from the reference domain.
  bit_sync #(.WIDTH(4)) uSync (
    .clk(serialClk),
    .rstN(1'b1),
    .d({rstN, latchEpoch, frameCheckOn, readTgl}),
    .q({rstS, epochS, checkS, readTglS})
  );

  // A new latch epoch means the host raised the latch, after a frame or with no clocks.
  assign realign = epochS ^ epochSeen_r;
  assign frameLen = checkS ? FRAME_LONG : FRAME_SHORT;
  assign cntNxt = realign ? REALIGN_COUNT : cnt_r + 6'h01;
  assign done = (cntNxt == frameLen);
  assign shiftNxt = {shift_r[30:0], serialIn};

  // Receive side: shift bits in and hand over each finished frame.
  always_ff @(posedge serialClk) begin
    if (!rstS) begin
      shift_r <= '0;
      cnt_r <= '0;
      epochSeen_r <= 1'b0;
      frameWord_r <= '0;
      frameIs32_r <= 1'b0;
      frameTgl_r <= 1'b0;
    end else begin
      shift_r <= shiftNxt;
      epochSeen_r <= epochS;
      if (done) begin
        cnt_r <= '0;
        frameWord_r <= shiftNxt;
        frameIs32_r <= checkS;
        frameTgl_r <= ~frameTgl_r;
      end else begin
        cnt_r <= cntNxt;
      end
    end
  end

  // Transmit side: a new readback word is loaded at a frame boundary.
  // readback word out.
  always_ff @(posedge serialClk) begin
    if (!rstS) begin
      outShift_r <= '0;
      outOe_r <= 1'b0;
      readSeen_r <= 1'b0;
    end else if (done) begin
      readSeen_r <= readTglS;
      outOe_r <= readTglS ^ readSeen_r;
      outShift_r <= (readTglS ^ readSeen_r) ? readWord : '0;
    end else begin
      outShift_r <= {outShift_r[30:0], 1'b0};
    end
  end

  assign frameWord = frameWord_r;
  assign frameIs32 = frameIs32_r;
  assign frameTgl = frameTgl_r;
  assign serialOut = outShift_r[31];
  assign serialOutOe = outOe_r;

  chk_realign_count: assert property (
    @(posedge serialClk) disable iff (!rstS)
    realign |=> (cnt_r == REALIGN_COUNT) || (frameLen == REALIGN_COUNT))
    else $error("Bit counter not realigned after latch.");

  chk_long_frame: assert property (
    @(posedge serialClk) disable iff (!rstS)
    checkS && !realign && cnt_r == 6'h1F |=> frameTgl_r != $past(frameTgl_r))
    else $error("Checked frame not closed at thirty two clocks.");
endmodule

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic serialOut,
  input wire logic serialOutOe,
  output logic serialClk,
  output logic serialIn,
  output logic latchIn
);
  localparam logic [7:0] CRC_POLY_H = 8'h07;
  logic crcOn;
  // Last readback word seen on the serial output, and its drive enable.
  logic [31:0] rd;
  logic rdOe;
  // The link clock stands still between frames.
  initial begin
    serialClk = 0;
    serialIn = 0;
    latchIn = 0;
    crcOn = 0;
    rd = '0;
    rdOe = 0;
  end
  function automatic logic [7:0] crc8(input logic [23:0] p);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? CRC_POLY_H : 8'h00);
    end
    return c;
  endfunction
  // check byte only in long frames
  task automatic send(input logic [7:0] a, input logic [15:0] v,
                      input logic bad);
    logic [31:0] w;
    int n;
    w = {a, v, crc8({a, v}) ^ {7'h00, bad}};
    n = crcOn ? 32 : 24;
    rd = '0;
    for (int i = 31; i >= 32 - n; i--) begin
      serialIn = w[i];
      // Readback bit is taken before the rising edge that shifts it on.
      rd = {rd[30:0], serialOut};
      if (i == 31) begin
        rdOe = serialOutOe;
      end
      #32 serialClk = 1;
      #32 serialClk = 0;
    end
    serialIn = ~serialIn;  // Idle line shows the inverse of the last bit.
    #200;
  endtask
  // latch toggle that commits or realigns
  task automatic pulse();
    latchIn = 1;
    #300 latchIn = 0;
    #400;
  endtask
  // Free clocks with data low, used only around reset to settle the link.
  task automatic clocks(input int n);
    repeat (n) begin
      #32 serialClk = 1;
      #32 serialClk = 0;
    end
  endtask
endmodule

// ### current_dac_fault_monitor_bench.sv
`timescale 1ns/1ps
module current_dac_fault_monitor_bench;
  import cdfm_pkg::*;
  logic ref_clk, rst_n, clr, aOk, open, hot, cool;
  logic serialClk, serialIn, latchIn, pinOn, alarmOut, alarmOe;
  logic wdF, ckF, sOut, sOe, dOk, head;
  logic [14:0] ua;
  logic [15:0] code, v;
  logic [2:0] rng;
  int mismatches, n_checks;
  int spans[3] = '{SPAN_16_UA, SPAN_20_UA, SPAN_24_UA};
  int offs[3] = '{OFFSET_4_UA, 0, 0};
  logic [2:0] rcode[3] = '{RANGE_4_20, RANGE_0_20, RANGE_0_24};
  host_model host_i (.serialOut(sOut), .serialOutOe(sOe),
    .serialClk(serialClk), .serialIn(serialIn), .latchIn(latchIn));
  current_dac_fault_monitor #(.WD_TICKS_P0(40), .WD_TICKS_P1(60),
    .WD_TICKS_P2(80), .WD_TICKS_P3(100)) current_dac_fault_monitor_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .serialClk(serialClk),
    .serialIn(serialIn), .latchIn(latchIn), .outputClearPin(clr),
    .logicSupplyOk(dOk), .analogSupplyOk(aOk), .openLoadIn(open),
    .headroomLowIn(head), .dieHotIn(hot), .dieCooledIn(cool),
    .alarmLineIn(alarmOe), .currentOutputPinOn(pinOn),
    .currentOutputPinUa(ua), .dacCode(code), .rangeSel(rng),
    .alarmOut(alarmOut), .alarmOe(alarmOe), .serialOut(sOut),
    .serialOutOe(sOe), .watchdogFaultFlag(wdF), .frameCheckFaultFlag(ckF));
  // Core clock of 100 ns.
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Compares a result, allowing one count of rounding when asked.
  task automatic chk(input logic [31:0] got, exp, input bit tol);
    n_checks++;
    if (!(got === exp || (tol && (got === exp + 1 || got + 1 === exp))))
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic bad = 0);
    host_i.send(a, d, bad);
    host_i.pulse();
    tick(20);
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence; design inputs move by non-blocking assignment.
  initial begin
    {rst_n, clr, open, hot, head} = 0;
    {aOk, cool, dOk} = 3'b111;
    void'($urandom(54));
    // The link clock must run while reset is low to clear the link side.
    fork
      host_i.clocks(4);
      begin
        tick(3);
        rst_n <= 1;
      end
    join
    tick(6);
    host_i.clocks(2);
    host_i.pulse();
    chk(pinOn, 0, 0);
    chk({wdF, ckF}, 0, 0);
    for (int r = 0; r < 3; r++) begin
      v = $urandom;
      wr(ADDR_CONTROL, {13'h0, rcode[r]});
      wr(ADDR_CONTROL, 16'h1000 | 16'(rcode[r]));
      wr(ADDR_DATA, v);
      chk(rng, rcode[r], 0);
      chk(code, v, 0);
      chk(ua, offs[r] + ((longint'(v) * spans[r]) >> 16), 1);
    end
    $display("end of range test");
    clr <= 1;
    tick(6);
    chk(code, 0, 0);
    wr(ADDR_DATA, 16'h1234);
    chk(code, 0, 0);
    clr <= 0;
    tick(6);
    chk(code, 0, 0);
    host_i.pulse();
    tick(20);
    chk(code, v, 0);
    $display("end of clear test");
    open <= 1;
    tick(6);
    chk(alarmOe, 1, 0);
    {open, head} <= 2'b01;
    tick(6);
    chk(alarmOe, 1, 0);
    {head, hot, cool} <= 3'b010;
    tick(6);
    chk(alarmOe, 1, 0);
    hot <= 0;
    tick(6);
    chk(alarmOe, 1, 0);
    cool <= 1;
    tick(6);
    chk({alarmOe, alarmOut}, 0, 0);
    $display("end of alarm test");
    chk(wdF, 0, 0);
    wr(ADDR_CONFIG, 16'h0007);
    repeat (3) wr(ADDR_WD_REFRESH, 16'h0000);
    chk(wdF, 0, 0);
    wr(ADDR_CONFIG, 16'h0004);
    for (int i = 0; i < 300 && wdF !== 1'b1; i++) tick(1);
    chk(wdF, 1, 0);
    if (wdF !== 1'b1) wrap_up();
    tick(30);
    chk({wdF, alarmOe}, 3, 0);
    wr(ADDR_CONFIG, 16'h0000);
    chk(wdF, 0, 0);
    $display("end of watchdog test");
    wr(ADDR_CONFIG, 16'h0008);
    host_i.pulse();
    host_i.crcOn = 1;
    wr(ADDR_DATA, 16'hA5A5);
    chk(code, 16'hA5A5, 0);
    wr(ADDR_DATA, 16'h0F0F, 1);
    chk({ckF, alarmOe}, 3, 0);
    chk(code, 16'hA5A5, 0);
    wr(ADDR_READ_SEL, 16'h0000);
    repeat (2) wr(ADDR_WD_REFRESH, 16'h0000);
    chk(host_i.rd, {8'h00, 16'h0022, host_i.crc8(24'h000022)}, 0);
    chk(host_i.rdOe, 1, 0);
    wr(ADDR_SOFT_RESET, 16'h0000);
    host_i.crcOn = 0;
    chk({ckF, pinOn}, 0, 0);
    $display("end of frame check test");
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CONTROL, 16'h1006);
      wr(ADDR_DATA, 16'h8001);
      chk({pinOn, code}, 17'h18001, 0);
      {aOk, dOk} <= s ? 2'b10 : 2'b01;
      tick(6);
      chk({pinOn, code}, 0, 0);
      {aOk, dOk} <= 2'b11;
      tick(8);
      host_i.pulse();
      tick(2);
      chk({pinOn, code}, 0, 0);
      wr(ADDR_SOFT_RESET, 16'h0000);
      chk({pinOn, ckF, wdF}, 0, 0);
    end
    $display("end of supply test");
    wrap_up();
  end
endmodule
